// ---- logic/rcw_regs.svh ----
// offsets, fields, reset values and protocol constants of the classifier
// assumes a 9-bit word address on the register port
`ifndef RCW_REGS_SVH
`define RCW_REGS_SVH

// register port geometry
`define RCW_ADDR_W         9
`define RCW_DATA_W         16
// register word offsets
`define RCW_OFF_CONFIG     9'h000
`define RCW_OFF_TERM_ADDR  9'h001
`define RCW_OFF_LAST_CMD   9'h002
`define RCW_OFF_STATUS     9'h003
`define RCW_OFF_COUNTS     9'h004
// legality table window: bit 8 of the address selects it
`define RCW_TABLE_SEL_BIT  8
`define RCW_TABLE_WORDS    256
`define RCW_TABLE_IDX_W    8
// configuration register fields
`define RCW_CFG_EXEC_BIT   0
`define RCW_CFG_BCST_BIT   1
`define RCW_CFG_UMC_BIT    2
`define RCW_CFG_SOFTWARE_RESET_BIT   3
// reset values
`define RCW_RST_CFG        4'h0
`define RCW_RST_TADDR      5'h00
`define RCW_RST_WORD       16'h0000
`define RCW_RST_COUNT      8'h00
// command word fields
`define RCW_TA_MSB         15
`define RCW_TA_LSB         11
`define RCW_TR_BIT         10
`define RCW_SA_MSB         9
`define RCW_SA_LSB         5
`define RCW_WC_MSB         4
`define RCW_WC_LSB         0
// protocol values
`define RCW_BCAST_ADDR     5'h1F
`define RCW_SA_MODE_LO     5'h00
`define RCW_SA_MODE_HI     5'h1F
`define RCW_WC_ZERO        5'h00
`define RCW_WC_FULL        6'h20
`define RCW_MC_DATA_MIN    5'h10
`define RCW_MC_RSV_TX_LO   5'h09
`define RCW_MC_RSV_TX_HI   5'h0F
`define RCW_MC_RSV_LO      5'h16
`define RCW_MC_16          5'h10
`define RCW_MC_17          5'h11
`define RCW_MC_18          5'h12
`define RCW_MC_19          5'h13
`define RCW_MC_20          5'h14
`define RCW_MC_21          5'h15
`define RCW_ONE_WORD       6'h01
`define RCW_NO_WORDS       6'h00

`endif

// ---- logic/rcw_pkg.sv ----
// types shared by the command word classifier.
// assumes rcw_regs.svh is on the include path.
`include "rcw_regs.svh"

package rcw_pkg;

   // legality table, one flip-flop word per index
   typedef logic [`RCW_TABLE_WORDS-1:0][`RCW_DATA_W-1:0] rcw_table_t;

   // whole state of the classifier
   typedef struct packed {
      logic [3:0]              cfg;         // configuration bits
      logic [4:0]              term_addr;   // own terminal address
      rcw_table_t              table_q;     // legality table
      logic [`RCW_DATA_W-1:0]  rd_data;     // read answer
      logic [`RCW_DATA_W-1:0]  last_cmd;    // last accepted command
      logic                    accept;      // one-cycle accept pulse
      logic                    bcast;       // broadcast command
      logic                    mode;        // mode command
      logic                    transmit;    // terminal transmits
      logic [4:0]              subaddr;     // subaddress field
      logic [5:0]              word_count;  // 1..32 data words, 0 for a mode command
      logic [4:0]              mode_code;   // mode code field
      logic                    undef;       // undefined mode command
      logic                    reserved;    // reserved mode command
      logic                    illegal;     // legality bit was set
      logic                    status_reply;// send a status word
      logic                    msg_error;   // message error in status
      logic [5:0]              tx_words;    // data words to transmit
      logic [5:0]              rx_words;    // data words to receive
      logic                    invalid;     // one-cycle invalid word pulse
      logic [7:0]              accept_cnt;  // accepted commands
      logic [7:0]              reject_cnt;  // rejected words
   } rcw_state_s;

endpackage

// ---- logic/rcw_classifier.sv ----
// remote terminal command word classifier and reply decision.
// assumes a same-clock word decoder giving one-cycle words; no synchroniser.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "rcw_regs.svh"

module rcw_classifier
   import rcw_pkg::*;
(
   input  wire logic                   clk_sys_in,        // 125 MHz system clock
   input  wire logic                   rst_in,            // synchronous reset, high
   // register port
   input  wire logic [`RCW_ADDR_W-1:0] reg_addr_in,       // word address
   input  wire logic [`RCW_DATA_W-1:0] reg_wdata_in,      // write data
   input  wire logic                   reg_wr_in,         // write strobe
   input  wire logic                   reg_rd_in,         // read strobe
   output logic      [`RCW_DATA_W-1:0] reg_rdata_out,     // read data, next cycle
   // received word from the decoder
   input  wire logic                   word_strobe_in,    // word present, one cycle
   input  wire logic                   word_cmd_sync_in,  // command sync seen
   input  wire logic                   word_sync_ok_in,   // sync encoding correct
   input  wire logic                   word_manch_ok_in,  // manchester ii correct
   input  wire logic                   word_count_ok_in,  // bit count correct
   input  wire logic [`RCW_DATA_W-1:0] word_data_in,      // sixteen data bits
   input  wire logic                   word_parity_in,    // received parity bit
   // classification result
   output logic                        cmd_accept_out,    // accepted command pulse
   output logic [`RCW_DATA_W-1:0]      cmd_word_out,      // accepted command word
   output logic                        cmd_bcast_out,     // broadcast command
   output logic                        cmd_mode_out,      // mode command
   output logic                        cmd_transmit_out,  // terminal transmits
   output logic [4:0]                  cmd_subaddr_out,   // subaddress field
   output logic [5:0]                  cmd_word_count_out,// 1..32 data words, 0 for mode
   output logic [4:0]                  cmd_mode_code_out, // mode code field
   output logic                        cmd_undefined_out, // undefined mode command
   output logic                        cmd_reserved_out,  // reserved mode command
   output logic                        cmd_illegal_out,   // legality bit set
   output logic                        status_reply_out,  // send status word
   output logic                        msg_error_out,     // message error bit
   output logic [5:0]                  tx_words_out,      // data words to send
   output logic [5:0]                  rx_words_out,      // data words to take
   output logic                        word_invalid_out   // invalid word pulse
);

   rcw_state_s s;       // registered state
   rcw_state_s next_s;  // next state

   // odd parity over data plus parity bit
   function automatic logic parity_ok(input logic [`RCW_DATA_W-1:0] d,
                                      input logic p);
      parity_ok = ^{d, p};
   endfunction

   // the twenty-two undefined mode commands
   function automatic logic is_undefined(input logic [4:0] mc, input logic tr);
      is_undefined = (!tr && mc < `RCW_MC_DATA_MIN)
         || (!tr && (mc == `RCW_MC_16 || mc == `RCW_MC_18 || mc == `RCW_MC_19))
         || (tr && (mc == `RCW_MC_17 || mc == `RCW_MC_20 || mc == `RCW_MC_21));
   endfunction

   // the twenty-seven reserved mode commands
   function automatic logic is_reserved(input logic [4:0] mc, input logic tr);
      is_reserved = (tr && mc >= `RCW_MC_RSV_TX_LO && mc <= `RCW_MC_RSV_TX_HI)
         || (mc >= `RCW_MC_RSV_LO);
   endfunction

   // word count field to a number of data words
   function automatic logic [5:0] words_of(input logic [4:0] wc);
      words_of = (wc == `RCW_WC_ZERO) ? `RCW_WC_FULL : {1'b0, wc};
   endfunction

   // decoded fields of the incoming word, by name
   logic [4:0] f_ta;        // terminal address field
   logic       f_tr;        // transmit/receive bit
   logic [4:0] f_sa;        // subaddress field
   logic [4:0] f_wc;        // word count or mode code
   logic       f_mode;      // subaddress marks a mode command
   logic       f_bcast;     // broadcast address
   logic       f_valid;     // word passed every check
   logic       f_ours;      // addressed to this terminal
   logic       f_undef;     // undefined mode command
   logic       f_drop;      // command to be disregarded
   logic [`RCW_TABLE_IDX_W-1:0] f_idx;  // legality word index
   logic       f_leg_bit;   // fetched legality bit

   // field split and checks, all combinational
   always_comb
   begin
      // only the sixteen data bits go on; sync and parity stop here
      f_ta    = word_data_in[`RCW_TA_MSB:`RCW_TA_LSB];
      f_tr    = word_data_in[`RCW_TR_BIT];
      f_sa    = word_data_in[`RCW_SA_MSB:`RCW_SA_LSB];
      f_wc    = word_data_in[`RCW_WC_MSB:`RCW_WC_LSB];
      // all four checks together decide validity
      f_valid = word_sync_ok_in && word_manch_ok_in && word_count_ok_in
                && parity_ok(word_data_in, word_parity_in);
      // subaddress 0 or 31 means a mode command
      f_mode  = (f_sa == `RCW_SA_MODE_LO) || (f_sa == `RCW_SA_MODE_HI);
      // address 31 reaches every terminal unless rejected
      f_bcast = (f_ta == `RCW_BCAST_ADDR);
      // broadcast wins over an own address of 31
      f_ours  = f_bcast ? !s.cfg[`RCW_CFG_BCST_BIT]
                        : (f_ta == s.term_addr);
      f_undef = f_mode && is_undefined(f_wc, f_tr);
      // undefined reject turns these into disregarded commands
      f_drop  = !f_ours || (f_undef && s.cfg[`RCW_CFG_UMC_BIT]);
      // table word {broadcast, t/r, subaddress, count msb}, bit = count low
      f_idx   = {f_bcast, f_tr, f_sa, f_wc[`RCW_WC_MSB]};
      f_leg_bit = s.table_q[f_idx][f_wc[3:0]];
   end

   // next state
   always_comb
   begin
      next_s          = s;
      // pulses last one cycle
      next_s.accept   = 1'b0;
      next_s.invalid  = 1'b0;
      // software reset bit clears itself
      next_s.cfg[`RCW_CFG_SOFTWARE_RESET_BIT] = 1'b0;
      next_s.rd_data  = `RCW_RST_WORD;

      // register writes
      if (reg_wr_in)
      begin
         if (reg_addr_in[`RCW_TABLE_SEL_BIT])
         begin
            // legality table word
            next_s.table_q[reg_addr_in[`RCW_TABLE_IDX_W-1:0]] = reg_wdata_in;
         end
         else if (reg_addr_in == `RCW_OFF_CONFIG)
         begin
            next_s.cfg = reg_wdata_in[3:0];
         end
         else if (reg_addr_in == `RCW_OFF_TERM_ADDR)
         begin
            next_s.term_addr = reg_wdata_in[4:0];
         end
         // other offsets: write ignored
      end

      // register reads, answered one cycle later
      if (reg_rd_in)
      begin
         if (reg_addr_in[`RCW_TABLE_SEL_BIT])
         begin
            next_s.rd_data = s.table_q[reg_addr_in[`RCW_TABLE_IDX_W-1:0]];
         end
         else
         begin
            unique case (reg_addr_in)
               `RCW_OFF_CONFIG:    next_s.rd_data = {12'h000, s.cfg};
               `RCW_OFF_TERM_ADDR: next_s.rd_data = {11'h000, s.term_addr};
               `RCW_OFF_LAST_CMD:  next_s.rd_data = s.last_cmd;
               `RCW_OFF_STATUS:    next_s.rd_data = {7'h00, s.msg_error,
                                                     s.status_reply, s.illegal,
                                                     s.reserved, s.undef,
                                                     s.transmit, s.mode,
                                                     s.bcast, 1'b0};
               `RCW_OFF_COUNTS:    next_s.rd_data = {s.reject_cnt, s.accept_cnt};
               default:            next_s.rd_data = `RCW_RST_WORD;  // unmapped
            endcase
         end
      end

      // word handling; only while execution runs
      if (word_strobe_in && s.cfg[`RCW_CFG_EXEC_BIT])
      begin
         if (!f_valid)
         begin
            // a bad word touches no command state
            next_s.invalid    = 1'b1;
            next_s.reject_cnt = s.reject_cnt + 8'h01;
         end
         else if (word_cmd_sync_in)
         begin
            if (f_drop)
            begin
               // disregarded entirely: no reply, status kept
               next_s.reject_cnt = s.reject_cnt + 8'h01;
            end
            else
            begin
               next_s.accept     = 1'b1;
               next_s.accept_cnt = s.accept_cnt + 8'h01;
               next_s.last_cmd   = word_data_in;
               next_s.bcast      = f_bcast;
               next_s.mode       = f_mode;
               next_s.transmit   = f_tr;
               next_s.subaddr    = f_sa;
               next_s.mode_code  = f_mode ? f_wc : `RCW_WC_ZERO;
               next_s.word_count = f_mode ? `RCW_NO_WORDS : words_of(f_wc);
               next_s.undef      = f_undef;
               next_s.reserved   = f_mode && is_reserved(f_wc, f_tr);
               next_s.illegal    = f_leg_bit;
               // broadcasts never get a status word on the bus
               next_s.status_reply = !f_bcast;
               next_s.msg_error    = f_leg_bit;
               next_s.tx_words     = `RCW_NO_WORDS;
               next_s.rx_words     = `RCW_NO_WORDS;
               if (!f_mode)
               begin
                  // subaddress command moves its full count one way
                  if (f_tr)
                  begin
                     // illegal transmit sends status only
                     next_s.tx_words = f_leg_bit ? `RCW_NO_WORDS
                                                 : words_of(f_wc);
                  end
                  else
                  begin
                     next_s.rx_words = words_of(f_wc);
                  end
               end
               else if (f_wc >= `RCW_MC_DATA_MIN)
               begin
                  // one mode data word, direction by t/r
                  if (f_tr)
                  begin
                     next_s.tx_words = f_leg_bit ? `RCW_NO_WORDS
                                                 : `RCW_ONE_WORD;
                  end
                  else
                  begin
                     next_s.rx_words = `RCW_ONE_WORD;
                  end
               end
               // codes below 16 carry no data either way
            end
         end
         // data-sync words are not commands and leave state alone
      end

      // software reset clears last command, reply decision, illegal flag, tx and rx words and counters but keeps table, setup and the other command fields
      if (s.cfg[`RCW_CFG_SOFTWARE_RESET_BIT])
      begin
         next_s.accept       = 1'b0;
         next_s.invalid      = 1'b0;
         next_s.last_cmd     = `RCW_RST_WORD;
         next_s.status_reply = 1'b0;
         next_s.msg_error    = 1'b0;
         next_s.illegal      = 1'b0;
         next_s.tx_words     = `RCW_NO_WORDS;
         next_s.rx_words     = `RCW_NO_WORDS;
         next_s.accept_cnt   = `RCW_RST_COUNT;
         next_s.reject_cnt   = `RCW_RST_COUNT;
      end
   end

   // state register; reset clears config and the legality table
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s           <= '0;
         s.cfg       <= `RCW_RST_CFG;
         s.term_addr <= `RCW_RST_TADDR;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs straight from state flip-flops
   assign reg_rdata_out      = s.rd_data;
   assign cmd_accept_out     = s.accept;
   assign cmd_word_out       = s.last_cmd;
   assign cmd_bcast_out      = s.bcast;
   assign cmd_mode_out       = s.mode;
   assign cmd_transmit_out   = s.transmit;
   assign cmd_subaddr_out    = s.subaddr;
   assign cmd_word_count_out = s.word_count;
   assign cmd_mode_code_out  = s.mode_code;
   assign cmd_undefined_out  = s.undef;
   assign cmd_reserved_out   = s.reserved;
   assign cmd_illegal_out    = s.illegal;
   assign status_reply_out   = s.status_reply;
   assign msg_error_out      = s.msg_error;
   assign tx_words_out       = s.tx_words;
   assign rx_words_out       = s.rx_words;
   assign word_invalid_out   = s.invalid;

endmodule

// ---- verification/rcw_bc_model.sv ----
// bus controller side of the word port: one decoded word per call
// assumes the bench calls send() from one thread, one word at a time
`timescale 1ns/1ps
module rcw_bc_model (
   input  wire logic        clk_sys_in, // system clock
   output logic             stb_out,    // word present pulse
   output logic             csync_out,  // command sync type
   output logic             s_ok_out,   // sync encoding ok
   output logic             m_ok_out,   // manchester ok
   output logic             c_ok_out,   // bit count ok
   output logic [15:0]      data_out,   // sixteen data bits
   output logic             par_out     // parity bit
);
   // idle values at time zero
   initial
   begin
      stb_out = 1'b0;
      csync_out = 1'b0;
      s_ok_out = 1'b0;
      m_ok_out = 1'b0;
      c_ok_out = 1'b0;
      data_out = 16'h0000;
      par_out = 1'b0;
   end

   // bad bits: [0] parity, [1] sync, [2] manchester, [3] count
   task automatic send(input logic c, input logic [15:0] d, input logic [3:0] bad);
      @(posedge clk_sys_in);
      stb_out <= 1'b1;
      csync_out <= c;
      s_ok_out <= !bad[1];
      m_ok_out <= !bad[2];
      c_ok_out <= !bad[3];
      data_out <= d;
      par_out <= ~^d ^ bad[0];      // odd parity unless told
      @(posedge clk_sys_in);
      stb_out <= 1'b0;
      // released lines show a changed pattern, not the old word
      data_out <= ~d;
      c_ok_out <= bad[3];
      #1;
   endtask
endmodule

// ---- verification/rcw_classifier_monitor.sv ----
// concurrent checks on the classifier result ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module rcw_classifier_monitor (
   input wire logic        clk_sys_in, // system clock
   input wire logic        rst_in, // reset
   input wire logic        reg_rd_in, // read strobe
   input wire logic [15:0] reg_rdata_out, // read data
   input wire logic        word_strobe_in, // word present
   input wire logic        word_cmd_sync_in, // command sync
   input wire logic        word_sync_ok_in, // sync ok
   input wire logic        word_manch_ok_in, // manchester ok
   input wire logic        word_count_ok_in, // count ok
   input wire logic [15:0] word_data_in, // data bits
   input wire logic        word_parity_in, // parity bit
   input wire logic        cmd_accept_out, // accept pulse
   input wire logic [15:0] cmd_word_out, // accepted word
   input wire logic        cmd_bcast_out, // broadcast
   input wire logic        cmd_mode_out, // mode command
   input wire logic        cmd_transmit_out, // transmit
   input wire logic [5:0]  cmd_word_count_out, // word count
   input wire logic        cmd_undefined_out, // undefined mode
   input wire logic        cmd_reserved_out, // reserved mode
   input wire logic        cmd_illegal_out, // illegal
   input wire logic        msg_error_out, // message error
   input wire logic [5:0]  tx_words_out, // words to send
   input wire logic [5:0]  rx_words_out, // words to take
   input wire logic        word_invalid_out // invalid pulse
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   // undefined mode set, decoded apart from the design
   function automatic logic f_undef(input logic [15:0] w);
      return w[10] ? (w[4:0] inside {5'h11, 5'h14, 5'h15})
                   : (w[4:0] < 5'h11 || w[4:0] inside {5'h12, 5'h13});
   endfunction

   // a strobed word with any check failing
   sequence s_word_bad;
      word_strobe_in && !(word_sync_ok_in && word_manch_ok_in && word_count_ok_in
         && ^{word_data_in, word_parity_in});
   endsequence
   // a strobed word passing every check
   sequence s_word_good;
      word_strobe_in && word_sync_ok_in && word_manch_ok_in && word_count_ok_in
         && ^{word_data_in, word_parity_in};
   endsequence

   a_bad_word_drop: assert property (s_word_bad |=> !cmd_accept_out)
      else $error("failed word was accepted");
   a_data_sync_quiet: assert property (s_word_good ##0 !word_cmd_sync_in
      |=> !cmd_accept_out && !word_invalid_out) else $error("data word gave output");
   a_accept_cause: assert property (cmd_accept_out
      |-> $past(word_strobe_in && word_cmd_sync_in)) else $error("accept without command");
   a_word_kept: assert property (cmd_accept_out |-> cmd_word_out == $past(word_data_in))
      else $error("command word not kept");
   a_bcast_addr: assert property (cmd_accept_out
      |-> cmd_bcast_out == (cmd_word_out[15:11] == 5'h1F)) else $error("broadcast flag wrong");
   a_mode_split: assert property (cmd_accept_out
      |-> cmd_mode_out == (cmd_word_out[9:5] inside {5'h00, 5'h1F})) else $error("mode split");
   a_count_zero: assert property (cmd_accept_out && !cmd_mode_out
      |-> cmd_word_count_out == (cmd_word_out[4:0] == 5'h00 ? 6'h20 : {1'b0, cmd_word_out[4:0]}))
      else $error("word count decode");
   a_rx_direction: assert property (cmd_accept_out && !cmd_mode_out && !cmd_transmit_out
      |-> rx_words_out == cmd_word_count_out && tx_words_out == 6'h00) else $error("rx words");
   a_illegal_quiet: assert property (cmd_accept_out && cmd_illegal_out
      |-> msg_error_out && tx_words_out == 6'h00) else $error("illegal sent data");
   a_undef_class: assert property (cmd_accept_out && cmd_mode_out
      |-> cmd_undefined_out == f_undef(cmd_word_out)) else $error("undefined flag wrong");
   a_rsv_class: assert property (cmd_accept_out && cmd_mode_out
      |-> cmd_reserved_out == ((cmd_word_out[10] && cmd_word_out[4:0] inside {[5'h09:5'h0F]})
      || cmd_word_out[4:0] >= 5'h16)) else $error("reserved flag wrong");
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside its cycle");
endmodule

bind rcw_classifier rcw_classifier_monitor i_mon (.*);

// ---- verification/rcw_classifier_tb_top.sv ----
// self-checking bench for the command word classifier
// assumes rcw_bc_model feeds the word port; the bench owns the register port
`timescale 1ns/1ps
module rcw_classifier_tb_top;
   logic        clk_sys_in = 1'b0;     // 8 ns clock
   logic        rst_in     = 1'b1;     // reset
   logic [8:0]  addr       = 9'h000;   // register address
   logic [15:0] wdata      = 16'h0000; // write data
   logic        wr_s       = 1'b0;     // write strobe
   logic        rd_s       = 1'b0;     // read strobe
   logic [15:0] rdata, wd, cw;         // read data, word data, kept word
   logic        stb, csy, sok, mok, cok, par;
   logic        acc, bc, md, tx, und, rsv, ill, srp, mer, inv;
   logic [4:0]  sa, mc;
   logic [5:0]  wc, txw, rxw;
   int          err_count = 0;         // mismatches
   int          cmp_count = 0;         // comparisons

   always #4 clk_sys_in = ~clk_sys_in;

   rcw_classifier i_rcw_classifier (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_rdata_out(rdata), .word_strobe_in(stb), .word_cmd_sync_in(csy),
      .word_sync_ok_in(sok), .word_manch_ok_in(mok), .word_count_ok_in(cok),
      .word_data_in(wd), .word_parity_in(par), .cmd_accept_out(acc), .cmd_word_out(cw),
      .cmd_bcast_out(bc), .cmd_mode_out(md), .cmd_transmit_out(tx), .cmd_subaddr_out(sa),
      .cmd_word_count_out(wc), .cmd_mode_code_out(mc), .cmd_undefined_out(und),
      .cmd_reserved_out(rsv), .cmd_illegal_out(ill), .status_reply_out(srp),
      .msg_error_out(mer), .tx_words_out(txw), .rx_words_out(rxw), .word_invalid_out(inv));

   rcw_bc_model i_rcw_bc_model (.clk_sys_in(clk_sys_in), .stb_out(stb), .csync_out(csy),
      .s_ok_out(sok), .m_ok_out(mok), .c_ok_out(cok), .data_out(wd), .par_out(par));

   // one comparison, reported at once on mismatch
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // register write, one strobe cycle
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys_in);
      wr_s <= 1'b0;
   endtask

   // register read, data judged in the following cycle only
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(posedge clk_sys_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_in);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // well-formed command word from the bus controller
   task automatic cmd(input logic [4:0] ta, input logic t, input logic [4:0] s, w);
      i_rcw_bc_model.send(1'b1, {ta, t, s, w}, 4'h0);
   endtask

   // reset values, unmapped read, idle outputs
   task automatic t_reset;
      rd(9'h000, 16'h0000);
      rd(9'h001, 16'h0000);
      rd(9'h100, 16'h0000);
      rd(9'h1FF, 16'h0000);
      rd(9'h005, 16'h0000);
      chk(16'({acc, bc, md, und, ill, inv}), 16'h0000);
      $display("t_reset done");
   endtask

   // nothing answered before execution start
   task automatic t_no_exec;
      cmd(5'h00, 1'b1, 5'h02, 5'h00);
      chk(16'(acc), 16'h0000);
      i_rcw_bc_model.send(1'b1, 16'h0441, 4'h1);
      chk(16'(inv), 16'h0000);
      wr(9'h001, 16'h0005);
      wr(9'h000, 16'h0001);
      $display("t_no_exec done");
   endtask

   // subaddress commands, counts, own address
   task automatic t_sub;
      cmd(5'h05, 1'b1, 5'h02, 5'h00);
      chk(16'({acc, tx, srp, bc, wc, txw}), {4'b1110, 6'h20, 6'h20});
      cmd(5'h05, 1'b0, 5'h1E, 5'h1F);
      chk(16'({acc, tx, sa, rxw}), 16'({2'b10, 5'h1E, 6'h1F}));
      cmd(5'h06, 1'b1, 5'h02, 5'h01);
      chk(16'(acc), 16'h0000);
      rd(9'h002, {5'h05, 1'b0, 5'h1E, 5'h1F});
      rd(9'h004, 16'h0102);
      $display("t_sub done");
   endtask

   // failed checks pulse invalid and keep the last command
   task automatic t_valid;
      for (int k = 0; k < 4; k++)
      begin
         i_rcw_bc_model.send(1'b1, {5'h05, 1'b1, 5'h02, 5'h01}, 4'(1 << k));
         chk(16'({acc, inv}), 16'h0001);
         chk(cw, {5'h05, 1'b0, 5'h1E, 5'h1F});
      end
      i_rcw_bc_model.send(1'b0, {5'h05, 1'b1, 5'h02, 5'h01}, 4'h0);
      chk(16'({acc, inv}), 16'h0000);
      $display("t_valid done");
   endtask

   // every mode code with both directions, odd codes on subaddress 31, even codes on 0
   task automatic t_modes;
      int nu = 0;
      int nr = 0;
      logic u, r, t;
      logic [4:0] m;
      for (int i = 0; i < 64; i++)
      begin
         t = i[5];
         m = i[4:0];
         u = t ? (m inside {5'h11, 5'h14, 5'h15}) : (m < 5'h11 || m inside {5'h12, 5'h13});
         r = (t && m >= 5'h09 && m <= 5'h0F) || m >= 5'h16;
         nu += u;
         nr += r;
         cmd(5'h05, t, i[0] ? 5'h1F : 5'h00, m);
         chk({acc, md, und, rsv, txw, rxw},
             {2'b11, u, r, 6'(t && m >= 5'h10), 6'(!t && m >= 5'h10)});
         chk(16'({srp, mer, mc, wc}), 16'({2'b10, m, 6'h00}));
      end
      chk(16'(nu), 16'd22);
      chk(16'(nr), 16'd27);
      $display("t_modes done");
   endtask

   // undefined reject drops only undefined codes
   task automatic t_umc;
      wr(9'h000, 16'h0005);
      cmd(5'h05, 1'b0, 5'h00, 5'h05);
      chk(16'(acc), 16'h0000);
      cmd(5'h05, 1'b1, 5'h00, 5'h11);
      chk(16'(acc), 16'h0000);
      cmd(5'h05, 1'b0, 5'h00, 5'h11);
      chk(16'({acc, und}), 16'h0002);
      wr(9'h000, 16'h0001);
      $display("t_umc done");
   endtask

   // legality entries pick one bit per command
   task automatic t_illegal;
      wr(9'h144, 16'h0001);
      rd(9'h144, 16'h0001);
      cmd(5'h05, 1'b1, 5'h02, 5'h00);
      chk(16'({acc, ill, mer, srp, txw}), 16'({4'hF, 6'h00}));
      cmd(5'h05, 1'b1, 5'h02, 5'h01);
      chk(16'({acc, ill, txw}), 16'({2'b10, 6'h01}));
      wr(9'h141, 16'h0004);
      cmd(5'h05, 1'b1, 5'h00, 5'h12);
      chk(16'({acc, ill, mer, txw}), 16'({3'b111, 6'h00}));
      $display("t_illegal done");
   endtask

   // broadcast accepted without reply, then rejected; software reset
   task automatic t_bcast;
      cmd(5'h1F, 1'b0, 5'h02, 5'h03);
      chk(16'({acc, bc, srp, rxw}), 16'({3'b110, 6'h03}));
      wr(9'h000, 16'h0003);
      cmd(5'h1F, 1'b0, 5'h02, 5'h03);
      chk(16'({acc, inv}), 16'h0000);
      wr(9'h000, 16'h0009);
      rd(9'h004, 16'h0000);
      rd(9'h000, 16'h0001);
      chk(cw, 16'h0000);
      $display("t_bcast done");
   endtask

   // counts, verdict, end of run
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // main sequence after eight reset cycles
   initial
   begin
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      t_reset;
      t_no_exec;
      t_sub;
      t_valid;
      t_modes;
      t_umc;
      t_illegal;
      t_bcast;
      conclude;
   end

   // watchdog, well past the run length
   initial
   begin
      #100000;
      err_count++;
      conclude;
   end
endmodule
